// [hdl/auto_reload_timer_three.sv]
// Functional notes
// R1 - The timer is one 16-bit counter when split mode is 0, two 8-bit counters when it is 1.
// R2 - In 16-bit mode a wrap from all ones loads the 16-bit reload value instead of zero.
// R3 - In 16-bit mode the high overflow flag is set when the full count wraps.
// R4 - With the timer interrupt enabled, every 16-bit overflow requests an interrupt.
// R5 - In 16-bit mode, with interrupts and low-byte enable set, low byte wraps also request one.
// R6 - The low overflow flag is set whenever the low byte wraps, in either mode.
// R7 - In split mode each byte reloads from its own reload byte on its own overflow.
// R8 - Run control gates the whole counter in 16-bit mode but only the high byte in split mode.
// R9 - Each byte counts on system clock if its select is 1, else on clock/12 or external/8; in 16-bit mode only the low byte's select is used.
// R10 - The external divided-by-eight source is synchronised to the system clock before use.
// R11 - In split mode high overflows request interrupts, and low ones too with low-byte enable.
// R12 - Overflow flags are never cleared by hardware; software writes them to zero.
// R13 - With capture enabled, a low-frequency oscillator rising edge copies the count to reload.
// R14 - Control bit 1 reads as zero and ignores writes.
// R15 - The low count register shows the low byte of the count in either mode.
// R16 - The high count register shows the high byte of the count in either mode.
// R17 - The interrupt request holds while enabled and a flag with its enable is set.
`timescale 1ns/100ps
`default_nettype none
`include "timer3_params.svh"

module auto_reload_timer_three
    import timer3_pkg::*;
#(
    parameter int SYS_DIV = `T3_SYS_DIV,
    parameter int EXT_DIV = `T3_EXT_DIV
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       high_byte_clock_select,
    input  wire logic       low_byte_clock_select,
    input  wire logic       timer_irq_enable,
    input  wire logic       ext_osc_pin,
    input  wire logic       lfo_out_pin,
    output logic            irq_req
);

    localparam int SW = (SYS_DIV > 1) ? $clog2(SYS_DIV) : 1;
    localparam int EW = (EXT_DIV > 1) ? $clog2(EXT_DIV) : 1;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sfr_req_s       req;
    ctrl_s          ctrl_r;
    ctrl_s          ctrl_nxt;
    logic [15:0]    cnt_r;
    logic [15:0]    cnt_nxt;
    logic [7:0]     rld_lo_r;
    logic [7:0]     rld_lo_nxt;
    logic [7:0]     rld_hi_r;
    logic [7:0]     rld_hi_nxt;
    logic [SW-1:0]  pre_r;
    logic [SW-1:0]  pre_nxt;
    logic [EW-1:0]  ext_r;
    logic [EW-1:0]  ext_nxt;
    logic           cap_r;
    logic [7:0]     rdata_nxt;
    logic           irq_nxt;

    logic           ext_rise;
    logic           lfo_rise;

    logic           sys_tick;
    logic           ext_tick;
    logic [1:0]     byte_sel;
    logic [1:0]     byte_tick;

    logic           split;
    logic           run;
    logic [7:0]     lo;
    logic [7:0]     hi;
    logic           lo_step;
    logic           hi_step;
    logic           lo_wrap;
    logic           hi_wrap;
    logic           wide_wrap;
    logic [15:0]    wide_inc;
    logic [15:0]    wide_val;
    logic [7:0]     lo_val;
    logic [7:0]     hi_val;
    logic [15:0]    cnt_run;

    logic           wr_ctrl;
    logic           wr_rld_lo;
    logic           wr_rld_hi;
    logic           wr_cnt_lo;
    logic           wr_cnt_hi;
    logic           capture;
    logic           set_hi_flag;
    logic           set_lo_flag;
    ctrl_s          wr_ctrl_val;

    assign req = '{addr: sfr_addr, wr: sfr_wr, rd: sfr_rd,
                   wdata: sfr_wdata};

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pin_sync u_ext_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .pin_in (ext_osc_pin),
        .level  (),
        .rise   (ext_rise)
    );

    pin_sync u_lfo_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .pin_in (lfo_out_pin),
        .level  (),
        .rise   (lfo_rise)
    );

    // ------------------------------------------------------------------
    // Count sources
    // ------------------------------------------------------------------
    // Divide-by-twelve prescaler runs free so both bytes share one phase
    assign sys_tick = (pre_r == SW'(SYS_DIV - 1));
    assign pre_nxt  = sys_tick ? '0 : pre_r + 1'b1;

    // External source is counted only after the synchroniser, so a
    // fast oscillator cannot be followed beyond a quarter of mclk
    assign ext_tick = ext_rise && (ext_r == EW'(EXT_DIV - 1));     // R10
    assign ext_nxt  = !ext_rise ? ext_r :
                      (ext_tick ? '0 : ext_r + 1'b1);              // R10

    assign byte_sel = {high_byte_clock_select, low_byte_clock_select};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_src
            assign byte_tick[gi] = byte_sel[gi] ? 1'b1 :
                (ctrl_r.external_clock_select ? ext_tick
                                              : sys_tick);        // R9
        end
    endgenerate

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign split = ctrl_r.split_mode_select;
    assign run   = ctrl_r.run_control;
    assign lo    = cnt_r[7:0];
    assign hi    = cnt_r[15:8];

    // Low byte ignores run control in split mode
    assign lo_step = byte_tick[0] && (split || run);               // R8
    assign hi_step = byte_tick[1] && run;                          // R8

    assign wide_wrap = !split && lo_step && (cnt_r == '1);
    assign lo_wrap   = lo_step && (lo == '1);                      // R6
    assign hi_wrap   = split ? (hi_step && (hi == '1))
                             : wide_wrap;                          // R3

    assign wide_inc = cnt_r + 1'b1;
    assign wide_val = wide_wrap ? {rld_hi_r, rld_lo_r}
                                : wide_inc;                        // R2
    assign lo_val   = lo_wrap ? rld_lo_r : lo + 1'b1;              // R7
    assign hi_val   = (hi_step && (hi == '1)) ? rld_hi_r
                                               : hi + 1'b1;        // R7

    assign cnt_run = !split ? (lo_step ? wide_val : cnt_r) :       // R1
                     {hi_step ? hi_val : hi,
                      lo_step ? lo_val : lo};                      // R1

    // A software write to a count byte wins over that byte's step
    assign cnt_nxt = {wr_cnt_hi ? req.wdata : cnt_run[15:8],
                      wr_cnt_lo ? req.wdata : cnt_run[7:0]};

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    assign wr_ctrl   = req.wr && (req.addr == `T3_ADDR_CTRL);
    assign wr_rld_lo = req.wr && (req.addr == `T3_ADDR_RLD_LO);
    assign wr_rld_hi = req.wr && (req.addr == `T3_ADDR_RLD_HI);
    assign wr_cnt_lo = req.wr && (req.addr == `T3_ADDR_CNT_LO);
    assign wr_cnt_hi = req.wr && (req.addr == `T3_ADDR_CNT_HI);

    assign capture = lfo_rise && ctrl_r.lfo_capture_enable;        // R13

    // Capture takes the count before this edge's step and beats a write
    assign rld_lo_nxt = capture ? lo :
                        (wr_rld_lo ? req.wdata : rld_lo_r);        // R13
    assign rld_hi_nxt = capture ? hi :
                        (wr_rld_hi ? req.wdata : rld_hi_r);        // R13

    assign set_hi_flag = hi_wrap;                                  // R3
    assign set_lo_flag = lo_wrap;                                  // R6
    assign wr_ctrl_val = ctrl_s'(req.wdata);

    // Flags only ever set here; hardware set wins over a clearing write
    always_comb begin
        ctrl_nxt = wr_ctrl ? wr_ctrl_val : ctrl_r;
        ctrl_nxt.unused = `T3_UNUSED_BIT;                          // R14
        ctrl_nxt.high_overflow_flag =
            ctrl_nxt.high_overflow_flag || set_hi_flag;            // R12
        ctrl_nxt.low_overflow_flag =
            ctrl_nxt.low_overflow_flag || set_lo_flag;             // R12
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    assign rdata_nxt =
        (req.addr == `T3_ADDR_CTRL)   ? 8'(ctrl_r)  :              // R14
        (req.addr == `T3_ADDR_RLD_LO) ? rld_lo_r    :
        (req.addr == `T3_ADDR_RLD_HI) ? rld_hi_r    :
        (req.addr == `T3_ADDR_CNT_LO) ? lo          :              // R15
        (req.addr == `T3_ADDR_CNT_HI) ? hi          :              // R16
                                        `T3_READ_ZERO;

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // Level from the sticky flags, so it lasts until software clears;
    // capture has no flag of its own and gives a one-cycle request
    assign irq_nxt = timer_irq_enable &&
                     (ctrl_r.high_overflow_flag ||                 // R4 R11
                      (ctrl_r.low_overflow_flag &&
                       ctrl_r.low_overflow_irq_enable) ||          // R5 R11
                      cap_r);                                      // R13 R17

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r   <= ctrl_s'(`T3_RESET_BYTE);
            cnt_r    <= `T3_RESET_WORD;
            rld_lo_r <= `T3_RESET_BYTE;
            rld_hi_r <= `T3_RESET_BYTE;
            pre_r    <= '0;
            ext_r    <= '0;
            cap_r    <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            cnt_r    <= cnt_nxt;
            rld_lo_r <= rld_lo_nxt;
            rld_hi_r <= rld_hi_nxt;
            pre_r    <= pre_nxt;
            ext_r    <= ext_nxt;
            cap_r    <= capture;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= `T3_READ_ZERO;
            irq_req   <= 1'b0;
        end else begin
            if (req.rd) begin
                sfr_rdata <= rdata_nxt;
            end
            irq_req <= irq_nxt;                                    // R17
        end
    end

endmodule : auto_reload_timer_three

`default_nettype wire

// [hdl/pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);

    logic ff1_r;
    logic ff2_r;
    logic ff3_r;

    // ------------------------------------------------------------------
    // Three stages; level moves only once stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ff1_r <= 1'b0;
            ff2_r <= 1'b0;
            ff3_r <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            ff1_r <= pin_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            if (ff2_r == ff3_r) begin
                level <= ff3_r;
            end
            rise <= (ff2_r == ff3_r) && ff3_r && !level;
        end
    end

endmodule : pin_sync

`default_nettype wire

// [shared/timer3_params.svh]
`ifndef TIMER3_PARAMS_SVH
`define TIMER3_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define T3_ADDR_CTRL    8'h91
`define T3_ADDR_RLD_LO  8'h92
`define T3_ADDR_RLD_HI  8'h93
`define T3_ADDR_CNT_LO  8'h94
`define T3_ADDR_CNT_HI  8'h95

// ----------------------------------------------------------------------
// Reset values and fixed read values
// ----------------------------------------------------------------------
`define T3_RESET_BYTE   8'h00
`define T3_RESET_WORD   16'h0000
`define T3_READ_ZERO    8'h00
`define T3_UNUSED_BIT   1'b0

// ----------------------------------------------------------------------
// Prescaler divisions
// ----------------------------------------------------------------------
`define T3_SYS_DIV      12
`define T3_EXT_DIV      8

`endif

// [shared/timer3_pkg.sv]
package timer3_pkg;

    // ------------------------------------------------------------------
    // Control register layout, bit 7 first
    // ------------------------------------------------------------------
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic lfo_capture_enable;
        logic split_mode_select;
        logic run_control;
        logic unused;
        logic external_clock_select;
    } ctrl_s;

    // ------------------------------------------------------------------
    // Register bus request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_s;

endpackage : timer3_pkg

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "timer3_params.svh"

module tb
    import timer3_pkg::*;
;
    logic       mclk, resetn, sfr_wr, sfr_rd, hsel, lsel, ien, ext, lfo;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv;
    logic       irq_req, h, s;
    ctrl_s      c;
    int         err_count, check_count, cnt, rl, n, hf, lf, i, v;

    auto_reload_timer_three dut (
        .mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
        .timer_irq_enable(ien), .ext_osc_pin(ext), .lfo_out_pin(lfo),
        .irq_req(irq_req));

    // ----------------------------------------------------------------
    // Bus tasks and reference model
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input int e);
        check_count++;
        if (seen !== 16'(e)) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, 16'(e));
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge mclk);
        sfr_rd   <= 1'b0;
        #1 rv = sfr_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input int e);
        rd(a);
        chk(16'(rv), e);
    endtask : rdc

    // Split mode keeps two byte counters; only the high one obeys run
    task automatic step(input logic hi_t);
        int lo, hi;
        lo = cnt % 256;
        hi = cnt / 256;
        // A stopped 16-bit counter must not raise the low flag either
        if (c.split_mode_select || c.run_control) begin
            lf = (lo == 255) ? 1 : lf;
        end
        if (!c.split_mode_select && c.run_control) begin
            hf = (cnt == 65535) ? 1 : hf;
            cnt = (cnt == 65535) ? rl : cnt + 1;
        end else if (c.split_mode_select) begin
            lo = (lo == 255) ? rl % 256 : lo + 1;
            if (hi_t && c.run_control) begin
                hf = (hi == 255) ? 1 : hf;
                hi = (hi == 255) ? rl / 256 : hi + 1;
            end
            cnt = hi * 256 + lo;
        end
    endtask : step

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        repeat (4000) @(posedge mclk);
        err_count++;
        end_sim();
    end

    initial begin
        {resetn, sfr_wr, sfr_rd, hsel, lsel, ien, ext, lfo} = '0;
        {sfr_addr, sfr_wdata} = '0;
        void'($urandom(64));
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        // Count bytes first, before the divide-by-12 prescaler ticks
        for (i = 5; i > 0; i--) begin
            rdc(8'(8'h90 + i), 0);
        end
        wr(`T3_ADDR_CTRL, 8'h02);
        rdc(`T3_ADDR_CTRL, 0);
        wr(8'h96, 8'hff);
        rdc(8'h96, 0);
        $display("reset and map test done");
        for (int k = 0; k < 8; k++) begin
            c = ctrl_s'(8'h01);
            c.split_mode_select = k[0];
            c.low_overflow_irq_enable = 1'($urandom);
            c.run_control = (k % 3) != 1;
            rl = $urandom % 65536;
            cnt = 65535 - $urandom % 40;
            n = 1 + $urandom % 60;
            h = 1'($urandom);
            hf = 0;
            lf = 0;
            wr(`T3_ADDR_CTRL, c);
            wr(`T3_ADDR_RLD_LO, 8'(rl));
            wr(`T3_ADDR_RLD_HI, 8'(rl / 256));
            wr(`T3_ADDR_CNT_LO, 8'(cnt));
            wr(`T3_ADDR_CNT_HI, 8'(cnt / 256));
            @(posedge mclk);
            lsel <= 1'b1;
            hsel <= h;
            ien  <= 1'($urandom);
            repeat (n) begin
                @(posedge mclk);
                step(h);
            end
            lsel <= 1'b0;
            hsel <= 1'b0;
            rdc(`T3_ADDR_CNT_LO, cnt % 256);
            rdc(`T3_ADDR_CNT_HI, cnt / 256);
            rdc(`T3_ADDR_CTRL, c | hf << 7 | lf << 6);
            chk(16'(irq_req), ien & (hf | lf & c[5]));
            rdc(`T3_ADDR_CTRL, c | hf << 7 | lf << 6);
            wr(`T3_ADDR_CTRL, c);
            @(posedge mclk);
            #1 chk(16'(irq_req), 0);
        end
        $display("reload and flag test done");
        wr(`T3_ADDR_CTRL, 8'h05);
        wr(`T3_ADDR_CNT_LO, 8'h00);
        wr(`T3_ADDR_CNT_HI, 8'h00);
        repeat (24) begin
            @(posedge mclk);
            ext <= 1'b1;
            repeat (4) @(posedge mclk);
            ext <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
        rdc(`T3_ADDR_CNT_LO, 3);
        $display("external clock test done");
        wr(`T3_ADDR_CTRL, 8'h04);
        repeat (120) @(posedge mclk);
        wr(`T3_ADDR_CTRL, 8'h05);
        rd(`T3_ADDR_CNT_LO);
        chk(16'(rv inside {[13:14]}), 1);
        $display("prescaler test done");
        wr(`T3_ADDR_CTRL, 8'h15);
        wr(`T3_ADDR_CNT_HI, 8'h01);
        wr(`T3_ADDR_CNT_LO, 8'h00);
        @(posedge mclk);
        lsel <= 1'b1;
        ien  <= 1'b1;
        s = 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge mclk);
            lfo <= (i >= 10);
            #1 s = s | irq_req;
        end
        @(posedge mclk);
        lsel <= 1'b0;
        lfo  <= 1'b0;
        rd(`T3_ADDR_RLD_LO);
        v = int'(rv);
        rd(`T3_ADDR_RLD_HI);
        v = v + 256 * int'(rv);
        chk(16'(v inside {[266:296]}), 1);
        chk(16'(s), 1);
        $display("capture test done");
        end_sim();
    end
endmodule : tb
`default_nettype wire

// [test/timer3_checker.sv]
`timescale 1ns/100ps
`default_nettype none
`include "timer3_params.svh"

module timer3_checker
    import timer3_pkg::*;
#(
    parameter int SYS_DIV = `T3_SYS_DIV,
    parameter int EXT_DIV = `T3_EXT_DIV
) (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       high_byte_clock_select,
    input wire logic       low_byte_clock_select,
    input wire logic       timer_irq_enable,
    input wire logic       ext_osc_pin,
    input wire logic       lfo_out_pin,
    input wire logic       irq_req
);
    // ----------------------------------------------------------------
    // Flags last seen by a control read; a control write forgets them
    // ----------------------------------------------------------------
    logic       rdv_r;
    logic [1:0] seen_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdv_r  <= 1'b0;
            seen_r <= 2'b00;
        end else begin
            rdv_r <= sfr_rd && sfr_addr == `T3_ADDR_CTRL;
            if (sfr_wr && sfr_addr == `T3_ADDR_CTRL) begin
                seen_r <= 2'b00;
            end else if (rdv_r) begin
                seen_r <= sfr_rdata[7:6];
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence ctrl_rd;
        sfr_rd && sfr_addr == `T3_ADDR_CTRL;
    endsequence
    sequence ctrl_shown;
        rdv_r && timer_irq_enable;
    endsequence

    AST_RESET_QUIET: assert property ($rose(resetn) |->
        !irq_req && sfr_rdata == 8'h00)
        else $error("irq or read data not clear after reset");
    AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (sfr_rd && !(sfr_addr inside
        {[`T3_ADDR_CTRL:`T3_ADDR_CNT_HI]}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_BIT1_ZERO: assert property (ctrl_rd |=> !sfr_rdata[1])
        else $error("control bit 1 read as one");
    AST_FLAG_STICKY: assert property (rdv_r |->
        (sfr_rdata[7:6] & seen_r) == seen_r)
        else $error("overflow flag cleared without a write");
    AST_IRQ_HIGH: assert property (ctrl_shown ##0 sfr_rdata[7] |=> irq_req)
        else $error("high flag set but no irq");
    AST_IRQ_LOW: assert property (ctrl_shown ##0
        (sfr_rdata[6] && sfr_rdata[5]) |=> irq_req)
        else $error("low flag enabled but no irq");
    AST_IRQ_MASK: assert property (!timer_irq_enable |=> !irq_req)
        else $error("irq while timer interrupt disabled");
endmodule : timer3_checker

bind auto_reload_timer_three timer3_checker #(
    .SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV)) chk_i (
    .mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .high_byte_clock_select(high_byte_clock_select),
    .low_byte_clock_select(low_byte_clock_select),
    .timer_irq_enable(timer_irq_enable), .ext_osc_pin(ext_osc_pin),
    .lfo_out_pin(lfo_out_pin), .irq_req(irq_req));
`default_nettype wire
